// [src/i2c_master_byte_engine.sv]
// Purpose: Byte transmit/receive engine of a two-wire master behind APB
// Assumes: pclk 200 MHz; bus lines open drain with external pull-ups
// Notes: Start, stop, restart and slave mode are handled elsewhere
// Summary of operation
// - Buffer write sets buffer-full and starts the baud generator.
// - Each bit is driven after clock falls; clock held low one period.
// - Clock released high for one period; data kept stable meanwhile.
// - On eighth falling edge clear buffer-full and release data line.
// - Address phase sends seven address bits then direction bit.
// - On ninth falling edge sample data line into acknowledge status.
// - Acknowledge status is bit 6 of second control register.
// - After ninth clock set interrupt flag, suspend, hold clock low.
// - Transmit buffer-full is status bit 0: set on write, cleared on eighth fall.
// - Buffer write during transmit sets collision flag and is dropped.
// - Collision flag cleared only by software.
// - Receive-enable (bit 3) starts receive only when idle; else ignored.
// - In receive, toggle clock each rollover and shift data in.
// - After eighth receive clock: clear enable, load buffer, flag, suspend.
// - Receive buffer-full set on load, cleared by buffer read.
// - Software sets ack-sequence enable (bit 4) to send an acknowledge.
// - Overflow set when a byte completes while buffer-full still set.
// - Buffer write during receive sets collision flag and is dropped.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_byte_engine #(
	parameter int BAUD_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output i2c_engine_pkg::od_pin_t scl_pin,
	input wire logic sda_i,
	output i2c_engine_pkg::od_pin_t sda_pin,
	output logic port_interrupt_flag
);
	// Pin synchronisers
	logic scl_m_r;
	logic scl_s_r;
	logic sda_m_r;
	logic sda_s_r;
	// Registers and engine state
	logic [7:0] transfer_buffer_r;
	logic [7:0] bit_shift_register_r;
	logic buffer_full_flag_r;
	logic write_collision_flag_r;
	logic receive_overflow_flag_r;
	logic port_interrupt_flag_r;
	logic ack_status_bit_r;
	logic ack_data_bit_r;
	logic receive_enable_bit_r;
	logic ack_sequence_enable_r;
	logic [BAUD_W-1:0] baud_reload_r;
	logic [BAUD_W-1:0] baud_cnt_r;
	logic [3:0] bit_cnt_r;
	logic scl_low_r;
	logic sda_low_r;
	i2c_engine_pkg::phase_t phase_r;
	i2c_engine_pkg::op_t op_r;
	logic [31:0] prdata_r;

	// Bus decode
	wire logic access = psel && penable;
	wire logic wr = access && pwrite;
	wire logic rd = access && !pwrite;
	wire logic hit_buf = paddr == i2c_engine_pkg::OFF_BUFFER;
	wire logic hit_stat = paddr == i2c_engine_pkg::OFF_STATUS;
	wire logic hit_ctrl = paddr == i2c_engine_pkg::OFF_CTRL2;
	wire logic hit_baud = paddr == i2c_engine_pkg::OFF_BAUD;
	wire logic mapped = hit_buf || hit_stat || hit_ctrl || hit_baud;
	wire logic busy = phase_r != i2c_engine_pkg::ST_IDLE;
	wire logic buf_wr = wr && hit_buf;
	wire logic buf_rd = rd && hit_buf;
	wire logic ctrl_wr = wr && hit_ctrl;
	wire logic stat_wr = wr && hit_stat;
	// Collision: buffer write while shifting in or out
	wire logic collide = buf_wr && busy;
	wire logic start_tx = buf_wr && !busy;
	// Receive start only from idle; a write while busy is dropped
	wire logic start_rx = ctrl_wr && !busy && pwdata[i2c_engine_pkg::CTRL_RECEIVE_ENABLE_BIT];
	wire logic start_ack = ctrl_wr && !busy && !start_rx
		&& pwdata[i2c_engine_pkg::CTRL_ACK_SEQUENCE_ENABLE];
	// Baud rollover; a zero reload still gives one cycle per phase
	// A low phase lasts reload plus one pclk cycles, a high phase two more for a nonzero reload, so software sets
	// the bit rate by loading the reload register before a transfer.
	// A reload written mid-byte takes effect at the next phase change.
	wire logic rollover = baud_cnt_r == '0;
	// Clock stretching: high phase counts only once the line is seen high
	wire logic scl_seen_high = scl_s_r;
	wire logic fall_evt = busy && phase_r == i2c_engine_pkg::ST_HIGH && rollover;
	wire logic rise_evt = busy && phase_r == i2c_engine_pkg::ST_LOW && rollover;
	wire logic [3:0] bit_next = bit_cnt_r + 4'h1;
	wire logic [3:0] op_bits = (op_r == i2c_engine_pkg::OP_TX) ? i2c_engine_pkg::BITS_ACK
		: (op_r == i2c_engine_pkg::OP_RX) ? i2c_engine_pkg::BITS_BYTE : 4'h1;
	wire logic last_fall = fall_evt && bit_next == op_bits;
	wire logic tx_eighth = fall_evt && op_r == i2c_engine_pkg::OP_TX
		&& bit_next == i2c_engine_pkg::BITS_BYTE;
	wire logic rx_done = last_fall && op_r == i2c_engine_pkg::OP_RX;
	wire logic tx_done = last_fall && op_r == i2c_engine_pkg::OP_TX;
	wire logic [7:0] shift_in = {bit_shift_register_r[6:0], sda_s_r};

	// Read mux
	wire logic [31:0] stat_word = {27'h0, busy, port_interrupt_flag_r,
		receive_overflow_flag_r, write_collision_flag_r, buffer_full_flag_r};
	wire logic [31:0] ctrl_word = {25'h0, ack_status_bit_r, ack_data_bit_r,
		ack_sequence_enable_r, receive_enable_bit_r, 3'h0};
	wire logic [31:0] rd_word = hit_buf ? {24'h0, transfer_buffer_r}
		: hit_stat ? stat_word
		: hit_ctrl ? ctrl_word
		: hit_baud ? {{(32-BAUD_W){1'b0}}, baud_reload_r} : 32'h0;

	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = prdata_r;
	assign port_interrupt_flag = port_interrupt_flag_r;
	assign scl_pin = '{o: 1'b0, oe: scl_low_r};
	assign sda_pin = '{o: 1'b0, oe: sda_low_r};

	// Two-flop synchronisers on both bus lines
	// Reset to the pull-up level so no false edge follows reset.
	// Only the second stage feeds logic; the first may be metastable.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
		end
		else
		begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
		end
	end

	// Read data registered in the access cycle, held between reads
	// Zero wait states: the answer is ready one edge after the access.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0;
		else if (rd)
			prdata_r <= rd_word;
	end

	// Baud period register, software loaded
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			baud_reload_r <= BAUD_W'(i2c_engine_pkg::BAUD_RESET);
		else if (wr && hit_baud)
			baud_reload_r <= pwdata[BAUD_W-1:0];
	end

	// Baud counter: reload at every phase change, stalls high until line high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			baud_cnt_r <= '0;
		else if (start_tx || start_rx || start_ack || fall_evt || rise_evt)
			baud_cnt_r <= baud_reload_r;
		else if (busy && !rollover && (phase_r == i2c_engine_pkg::ST_LOW || scl_seen_high))
			baud_cnt_r <= baud_cnt_r - 1'b1;
	end

	// Bit phase sequencer: low one period, high one period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_r <= i2c_engine_pkg::ST_IDLE;
			op_r <= i2c_engine_pkg::OP_TX;
			bit_cnt_r <= 4'h0;
		end
		else
		begin
			case (phase_r)
				i2c_engine_pkg::ST_IDLE:
				begin
					bit_cnt_r <= 4'h0;
					if (start_tx)
					begin
						op_r <= i2c_engine_pkg::OP_TX;
						phase_r <= i2c_engine_pkg::ST_LOW;
					end
					else if (start_rx)
					begin
						op_r <= i2c_engine_pkg::OP_RX;
						phase_r <= i2c_engine_pkg::ST_LOW;
					end
					else if (start_ack)
					begin
						op_r <= i2c_engine_pkg::OP_ACK;
						phase_r <= i2c_engine_pkg::ST_LOW;
					end
				end
				i2c_engine_pkg::ST_LOW:
					if (rise_evt)
						phase_r <= i2c_engine_pkg::ST_HIGH;
				i2c_engine_pkg::ST_HIGH:
					if (fall_evt)
					begin
						bit_cnt_r <= bit_next;
						// Suspend after last clock, line held low
						phase_r <= last_fall ? i2c_engine_pkg::ST_IDLE
							: i2c_engine_pkg::ST_LOW;
					end
				default:
					phase_r <= i2c_engine_pkg::ST_IDLE;
			endcase
		end
	end

	// Clock line: released in high phase and after reset, otherwise pulled low
	// A command pulls the clock low at once, so the first bit is set up
	// under a low clock; otherwise its rising edge would be lost
	// After the last clock of a byte the line stays held low until the
	// next command, which keeps the slave from seeing a stray edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			scl_low_r <= 1'b0;
		else if (start_tx || start_rx || start_ack)
			scl_low_r <= 1'b1;
		else if (rise_evt)
			scl_low_r <= 1'b0;
		else if (fall_evt)
			scl_low_r <= 1'b1;
	end

	// Data line drive: MSB first, address then direction bit
	// Data changes only at a command or on a falling clock event, so the line is steady
	// for the whole high phase and the slave may sample anywhere in it.
	// Receive and acknowledge share this register so that one driver
	// owns the data line at a time.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sda_low_r <= 1'b0;
			bit_shift_register_r <= i2c_engine_pkg::BYTE_RESET;
		end
		else if (start_tx)
		begin
			// First bit driven while clock low after falling edge
			bit_shift_register_r <= {pwdata[6:0], 1'b0};
			sda_low_r <= !pwdata[7];
		end
		else if (start_rx)
			sda_low_r <= 1'b0;
		else if (start_ack)
			sda_low_r <= !ack_data_bit_r;
		else if (fall_evt && op_r == i2c_engine_pkg::OP_TX)
		begin
			if (bit_next >= i2c_engine_pkg::BITS_BYTE)
				sda_low_r <= 1'b0; // Release for slave ack
			else
			begin
				sda_low_r <= !bit_shift_register_r[7];
				bit_shift_register_r <= {bit_shift_register_r[6:0], 1'b0};
			end
		end
		else if (fall_evt && op_r == i2c_engine_pkg::OP_ACK)
			sda_low_r <= 1'b0;
		else if (rise_evt && op_r == i2c_engine_pkg::OP_RX)
			bit_shift_register_r <= bit_shift_register_r; // Sample at high end
		else if (fall_evt && op_r == i2c_engine_pkg::OP_RX)
			bit_shift_register_r <= shift_in;
	end

	// Buffer and buffer-full flag
	// A received byte loading in the same cycle as a buffer read wins,
	// so a fresh byte is never reported as already consumed.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			transfer_buffer_r <= i2c_engine_pkg::BYTE_RESET;
			buffer_full_flag_r <= 1'b0;
		end
		else if (start_tx)
		begin
			transfer_buffer_r <= pwdata[7:0];
			buffer_full_flag_r <= 1'b1;
		end
		else if (rx_done)
		begin
			transfer_buffer_r <= shift_in;
			buffer_full_flag_r <= 1'b1;
		end
		else if (tx_eighth)
			buffer_full_flag_r <= 1'b0;
		else if (buf_rd)
			buffer_full_flag_r <= 1'b0;
	end

	// Sticky flags; hardware set wins over a same-cycle software clear
	// Writing one to a flag bit keeps it, so software can clear one flag
	// without losing another that was set meanwhile.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			write_collision_flag_r <= 1'b0;
			receive_overflow_flag_r <= 1'b0;
			port_interrupt_flag_r <= 1'b0;
		end
		else
		begin
			// Collision cleared only by a status write of zero
			if (collide)
				write_collision_flag_r <= 1'b1;
			else if (stat_wr && !pwdata[i2c_engine_pkg::STAT_WRITE_COLLISION_FLAG])
				write_collision_flag_r <= 1'b0;
			if (rx_done && buffer_full_flag_r && !buf_rd)
				receive_overflow_flag_r <= 1'b1;
			else if (stat_wr && !pwdata[i2c_engine_pkg::STAT_OV])
				receive_overflow_flag_r <= 1'b0;
			if (last_fall)
				port_interrupt_flag_r <= 1'b1;
			else if (stat_wr && !pwdata[i2c_engine_pkg::STAT_IF])
				port_interrupt_flag_r <= 1'b0;
		end
	end

	// Second control register: enables auto-clear, ack status sampled
	// The acknowledge level is taken from the synchronised line, which
	// still shows the high-phase value at the ninth falling event.
	// Enables are set only when idle; a busy write still updates the ack data bit.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ack_status_bit_r <= 1'b0;
			ack_data_bit_r <= 1'b0;
			receive_enable_bit_r <= 1'b0;
			ack_sequence_enable_r <= 1'b0;
		end
		else
		begin
			if (ctrl_wr)
				ack_data_bit_r <= pwdata[i2c_engine_pkg::CTRL_ACK_DATA_BIT];
			if (start_rx)
				receive_enable_bit_r <= 1'b1;
			else if (rx_done)
				receive_enable_bit_r <= 1'b0;
			if (start_ack)
				ack_sequence_enable_r <= 1'b1;
			else if (last_fall && op_r == i2c_engine_pkg::OP_ACK)
				ack_sequence_enable_r <= 1'b0;
			// Low line means acknowledged
			if (tx_done)
				ack_status_bit_r <= sda_s_r;
		end
	end
endmodule
`default_nettype wire

// [src/i2c_engine_pkg.sv]
// Purpose: Shared constants and types for the two-wire master byte engine
// Assumes: APB register access, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package i2c_engine_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_BUFFER = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_CTRL2 = 8'h08;
	localparam logic [7:0] OFF_BAUD = 8'h0C;
	// Status register fields
	localparam int STAT_BF = 0;
	localparam int STAT_WRITE_COLLISION_FLAG = 1;
	localparam int STAT_OV = 2;
	localparam int STAT_IF = 3;
	localparam int STAT_BUSY = 4;
	// Second control register fields
	localparam int CTRL_RECEIVE_ENABLE_BIT = 3;
	localparam int CTRL_ACK_SEQUENCE_ENABLE = 4;
	localparam int CTRL_ACK_DATA_BIT = 5;
	localparam int CTRL_ACK_STATUS_BIT = 6;
	// Reset values
	localparam logic [15:0] BAUD_RESET = 16'h0031;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// Bits per byte and per byte with acknowledge
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] BITS_ACK = 4'h9;
	typedef enum {ST_IDLE, ST_LOW, ST_HIGH} phase_t;
	typedef enum {OP_TX, OP_RX, OP_ACK} op_t;
	// Pin group of one open-drain line
	typedef struct packed {
		logic o;
		logic oe;
	} od_pin_t;
endpackage

// [sim/i2c_engine_props.sv]
// Purpose: Pin timing checks for the byte engine
// Assumes: Baud reload 7 is loaded before any transfer
// Notes: Phase lengths below follow from that reload
`timescale 1ns/1ps
`default_nettype none
module i2c_engine_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire i2c_engine_pkg::od_pin_t scl_pin,
	input wire i2c_engine_pkg::od_pin_t sda_pin,
	input wire logic port_interrupt_flag
);
	logic lo_r, hold_r, int_q_r, scl_q_r;
	logic [3:0] rel_r;
	// Buffer or control writes end a suspension; status writes do not
	wire cmd_wr = psel && penable && pwrite && (paddr == 8'h00 || paddr == 8'h08);
	wire int_rise = port_interrupt_flag && !int_q_r;
	wire scl_fell = scl_q_r && !scl_pin.oe;
	// Clock releases per byte, restarted when the byte ends
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			{lo_r, hold_r, int_q_r, scl_q_r} <= 4'h0;
			rel_r <= 4'h0;
		end
		else
		begin
			lo_r <= lo_r || scl_pin.oe;
			hold_r <= (hold_r || int_rise) && !cmd_wr;
			int_q_r <= port_interrupt_flag;
			scl_q_r <= scl_pin.oe;
			rel_r <= int_rise ? 4'h0 : rel_r + 4'(scl_fell);
		end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_low;
		$rose(scl_pin.oe) |-> scl_pin.oe[*8];
	endproperty
	a_low: assert property (p_low) else $error("clock low phase short");
	property p_high;
		$fell(scl_pin.oe) |-> !scl_pin.oe[*8] ##[1:6] scl_pin.oe;
	endproperty
	a_high: assert property (p_high) else $error("clock high phase length");
	property p_stable;
		lo_r && !scl_pin.oe && !$past(scl_pin.oe) |-> $stable(sda_pin.oe);
	endproperty
	a_stable: assert property (p_stable) else $error("data moved in high");
	property p_ack_free;
		rel_r == 4'h9 && !scl_pin.oe |-> !sda_pin.oe;
	endproperty
	a_ack_free: assert property (p_ack_free) else $error("data held in ack");
	property p_int_low;
		$rose(port_interrupt_flag) |-> scl_pin.oe;
	endproperty
	a_int_low: assert property (p_int_low) else $error("flag with clock up");
	property p_suspend;
		hold_r && !cmd_wr |=> scl_pin.oe && $stable(sda_pin.oe);
	endproperty
	a_suspend: assert property (p_suspend) else $error("pins moved idle");
	property p_tx_go;
		hold_r && cmd_wr && paddr == 8'h00 |-> ##[7:11] !scl_pin.oe;
	endproperty
	a_tx_go: assert property (p_tx_go) else $error("transmit not started");
	property p_rx_go;
		hold_r && cmd_wr && paddr == 8'h08 && pwdata[3] |-> ##[7:11] !scl_pin.oe;
	endproperty
	a_rx_go: assert property (p_rx_go) else $error("receive not started");
endmodule
bind i2c_master_byte_engine i2c_engine_props props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .scl_pin, .sda_pin,
	.port_interrupt_flag
);
`default_nettype wire

// [sim/i2c_slave_model.sv]
// Purpose: Addressed slave on the two-wire bus
// Assumes: Open-drain lines with pull-ups
// Notes: No clock stretching; frame_clr restarts the bit count
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic frame_clr,
	input wire logic rx_mode,
	input wire logic ack_en,
	input wire logic [7:0] tx_byte,
	output logic sda_oe,
	output logic [7:0] got_byte
);
	int rises;
	// Sample on the rising clock
	always @(posedge scl or posedge frame_clr)
		if (frame_clr)
			rises <= 0;
		else
		begin
			if (rises < 8)
				got_byte <= {got_byte[6:0], sda};
			rises <= rises + 1;
		end
	// Drive after a fall or on frame_clr, so data never moves while clock is high
	always @(negedge scl or posedge frame_clr)
		if (frame_clr)
			sda_oe <= rx_mode & ~tx_byte[7];
		else if (rx_mode)
			sda_oe <= (rises < 8) && !tx_byte[3'(7 - rises)];
		else
			sda_oe <= (rises == 8) && ack_en;
endmodule
`default_nettype wire

// [sim/i2c_master_byte_engine_tb.sv]
// Purpose: Self-checking bench for the byte engine
// Assumes: Baud reload 7, slave model on the bus
// Notes: Register cases run from a table
`timescale 1ns/1ps
`default_nettype none
module i2c_master_byte_engine_tb;
	localparam logic [7:0] BUF = 8'h00, ST = 8'h04, CT = 8'h08, BD = 8'h0C;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, port_interrupt_flag, sl_oe, err;
	i2c_engine_pkg::od_pin_t scl_pin, sda_pin;
	logic frame_clr = 1'b0, rx_mode = 1'b0, ack_en = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] got_byte;
	int err_count = 0, checks = 0, cyc = 0;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
	row_t rows [10] = '{'{0, ST, 0, 0, 0}, '{0, CT, 0, 0, 0}, '{0, BD, 0, 32'h31, 0},
		'{1, BD, 7, 0, 0}, '{0, BD, 0, 7, 0}, '{1, CT, 32'h20, 0, 0}, '{0, CT, 0, 32'h20, 0},
		'{1, CT, 0, 0, 0}, '{0, 8'h10, 0, 0, 1}, '{1, 8'h14, 32'hFF, 0, 1}};
	// Pull-ups: a line is low while any party drives it
	wire scl = ~scl_pin.oe;
	wire sda = ~(sda_pin.oe | sl_oe);
	i2c_master_byte_engine #(.BAUD_W(16)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl), .scl_pin, .sda_i(sda),
		.sda_pin, .port_interrupt_flag);
	i2c_slave_model slave (.scl, .sda, .frame_clr, .rx_mode, .ack_en, .tx_byte,
		.sda_oe(sl_oe), .got_byte);
	always #2.5 pclk = ~pclk;
	// Hang guard, far beyond a few bytes of traffic
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
		checks++;
		if (got !== x)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, x, got);
		end
	endtask
	// Setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1 rd = prdata;
	endtask
	// Clear the interrupt, arm the slave, issue the command
	task automatic xfer(input logic rx, ack, input logic [7:0] b, a, input logic [31:0] d);
		apb(1'b1, ST, 32'h6);
		rx_mode <= rx;
		ack_en <= ack;
		tx_byte <= b;
		frame_clr <= 1'b1;
		@(posedge pclk);
		frame_clr <= 1'b0;
		apb(1'b1, a, d);
	endtask
	task automatic wait_int();
		while (port_interrupt_flag !== 1'b1)
			@(posedge pclk);
		repeat (2) @(posedge pclk);
	endtask
	initial
	begin
		frame_clr <= 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		frame_clr <= 1'b0;
		#1 chk("pins idle", 32'h0, 32'({scl_pin.oe, sda_pin.oe}));
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk("slave error", 32'(rows[i].e), 32'(err));
			if (!rows[i].w)
				chk("read data", rows[i].x, rd);
		end
		$display("Test registers done");
		xfer(1'b0, 1'b1, 8'h00, BUF, 32'hA5);
		apb(1'b0, ST, 32'h0);
		chk("status busy", 32'h11, rd & 32'h17);
		apb(1'b1, BUF, 32'h3C);
		apb(1'b1, CT, 32'h8);
		wait_int();
		chk("sent byte", 32'hA5, 32'(got_byte));
		apb(1'b0, ST, 32'h0);
		chk("status end", 32'h0A, rd & 32'h1F);
		apb(1'b0, CT, 32'h0);
		chk("ack and receive_enable_bit", 32'h0, rd & 32'h48);
		apb(1'b0, BUF, 32'h0);
		chk("buffer kept", 32'hA5, rd & 32'hFF);
		apb(1'b1, ST, 32'h0);
		apb(1'b0, ST, 32'h0);
		chk("flags cleared", 32'h0, rd & 32'h0F);
		$display("Test transmit ack done");
		xfer(1'b0, 1'b0, 8'h00, BUF, 32'h5A);
		wait_int();
		chk("sent byte", 32'h5A, 32'(got_byte));
		apb(1'b0, CT, 32'h0);
		chk("nack status", 32'h40, rd & 32'h40);
		$display("Test transmit nack done");
		xfer(1'b1, 1'b0, 8'hC3, CT, 32'h8);
		apb(1'b1, BUF, 32'h77);
		wait_int();
		apb(1'b0, CT, 32'h0);
		chk("receive_enable_bit cleared", 32'h0, rd & 32'h8);
		apb(1'b0, ST, 32'h0);
		chk("rx status", 32'h0B, rd & 32'h1F);
		apb(1'b0, BUF, 32'h0);
		chk("rx byte", 32'hC3, rd);
		apb(1'b0, ST, 32'h0);
		chk("full cleared", 32'h0, rd & 32'h1);
		xfer(1'b0, 1'b0, 8'h00, CT, 32'h10);
		wait_int();
		apb(1'b0, CT, 32'h0);
		chk("ack seq cleared", 32'h0, rd & 32'h18);
		$display("Test receive done");
		xfer(1'b1, 1'b0, 8'h96, CT, 32'h8);
		wait_int();
		xfer(1'b1, 1'b0, 8'h69, CT, 32'h8);
		wait_int();
		apb(1'b0, ST, 32'h0);
		chk("overflow", 32'h05, rd & 32'h05);
		$display("Test overflow done");
		xfer(1'b0, 1'b1, 8'h00, BUF, 32'h81);
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		#1 chk("pins after reset", 32'h0, 32'({scl_pin.oe, sda_pin.oe}));
		apb(1'b0, ST, 32'h0);
		chk("status after reset", 32'h0, rd);
		$display("Test mid-run reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
